// ===== hdl/cbde_pkg.sv
/*
  Constants, encodings and state types shared by the execution unit for the
  compare-skip-if-less, decimal adjust and decrement instructions.
  Assumes one 10 MHz quarter-cycle clock, four quarters per instruction cycle.
*/
package cbde_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int Q_PER_CYCLE = 4;
  localparam int CYCLE_NS = Q_PER_CYCLE * (1000000000 / CLK_HZ);
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  localparam logic [6:0] CMP_OPC = 7'h30;
  localparam logic [5:0] DEC_OPC = 6'h01;
  localparam logic [15:0] ADJ_WORD = 16'h0007;
  localparam int BANK_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [8:0] LO_ADJ = 9'h006;
  localparam logic [8:0] HI_ADJ = 9'h060;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [7:0] IDX_MAX = 8'h5f;
  localparam logic [7:0] VF_EDGE = 8'h80;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  typedef enum logic [1:0] {
    CBDE_EXEC = 2'b00,
    CBDE_SKIP_A = 2'b01,
    CBDE_SKIP_B = 2'b10
  } cbde_state_t;
  typedef enum logic [1:0] {
    CBDE_OP_NONE = 2'b00,
    CBDE_OP_CMP = 2'b01,
    CBDE_OP_ADJ = 2'b10,
    CBDE_OP_DEC = 2'b11
  } cbde_op_t;
endpackage

// ===== hdl/cbde_qphase.sv
/*
  Quarter-cycle sequencer: counts Q1..Q4 on every clock.
  Assumes a synchronised active-low reset from the parent.
*/
`timescale 1ns/100ps
module cbde_qphase (
  input wire logic mclk,
  input wire logic rst_n_sync,
  output logic [1:0] q_phase
);
  typedef struct packed {
    logic [1:0] q;
  } cbde_qstate_t;

  cbde_qstate_t s_reg;
  cbde_qstate_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.q = s_reg.q + 2'h1;
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_phase = s_reg.q;
endmodule

// ===== hdl/cbde_exec.sv
/*
  Execution unit for compare-skip-if-less, decimal adjust and decrement.
  Holds the working register and status flags; data memory is outside,
  read one clock after mem_re, written during Q4 with mem_we.
*/
`timescale 1ns/100ps
module cbde_exec (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic next_two_word,
  input wire logic [3:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rdata,
  output logic [1:0] q_phase,
  output logic [11:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] working_register_file,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic negative_flag,
  output logic overflow_flag,
  output logic zero_flag,
  output logic skip_flush,
  output logic skip_idle
);
  typedef struct packed {
    cbde_pkg::cbde_state_t state;
    cbde_pkg::cbde_op_t op;
    logic [7:0] f;
    logic a;
    logic d;
    logic [11:0] addr;
    logic re;
    logic we;
    logic [7:0] wdata;
    logic [7:0] w;
    logic c;
    logic dcy;
    logic n;
    logic vf;
    logic z;
    logic [7:0] res;
    logic res_c;
    logic res_dcy;
    logic res_n;
    logic res_vf;
    logic res_z;
    logic less;
    logic flush;
    logic idle;
  } cbde_core_t;

  cbde_core_t r_reg;
  cbde_core_t r_next;
  logic [1:0] rst_sync_reg;
  logic rst_n_sync;
  logic [1:0] q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_reg[1];

  cbde_qphase u_qphase (
    .mclk(mclk),
    .rst_n_sync(rst_n_sync),
    .q_phase(q)
  );

  function automatic logic [11:0] phys_addr(input logic [7:0] f, input logic a,
                                            input logic [3:0] bank, input logic use_idx,
                                            input logic [11:0] base);
    if (a) begin
      phys_addr = {bank, f};
    end else if (use_idx && f <= cbde_pkg::IDX_MAX) begin
      phys_addr = base + {4'h0, f};
    end else if (f < cbde_pkg::ACC_SPLIT) begin
      phys_addr = {cbde_pkg::ACC_LO_BANK, f};
    end else begin
      phys_addr = {cbde_pkg::ACC_HI_BANK, f};
    end
  endfunction

  function automatic logic nib_over(input logic [3:0] nib);
    nib_over = nib > cbde_pkg::NIB_MAX;
  endfunction

  logic [8:0] adj_lo;
  logic [8:0] adj_hi;
  logic [7:0] dec_res;

  always_comb begin
    adj_lo = {1'b0, r_reg.w};
    if (nib_over(r_reg.w[3:0]) || r_reg.dcy) begin
      adj_lo = {1'b0, r_reg.w} + cbde_pkg::LO_ADJ;
    end
    adj_hi = adj_lo;
    if (nib_over(adj_lo[7:4]) || adj_lo[8] || r_reg.c) begin
      adj_hi = adj_lo + cbde_pkg::HI_ADJ;
    end
    dec_res = mem_rdata - cbde_pkg::ONE;
  end

  always_comb begin
    r_next = r_reg;
    r_next.re = 1'b0;
    r_next.we = 1'b0;
    r_next.flush = 1'b0;
    case (q)
      cbde_pkg::Q1: begin
        r_next.op = cbde_pkg::CBDE_OP_NONE;
        r_next.f = instr_word[7:0];
        r_next.a = instr_word[cbde_pkg::BANK_BIT];
        r_next.d = instr_word[cbde_pkg::DEST_BIT];
        if (r_reg.state == cbde_pkg::CBDE_EXEC && instr_valid) begin
          if (instr_word[15:9] == cbde_pkg::CMP_OPC) begin
            r_next.op = cbde_pkg::CBDE_OP_CMP;
            r_next.addr = phys_addr(instr_word[7:0], instr_word[cbde_pkg::BANK_BIT],
                                    bank_select_register, 1'b0, index_base);
            r_next.re = 1'b1;
          end else if (instr_word[15:10] == cbde_pkg::DEC_OPC) begin
            r_next.op = cbde_pkg::CBDE_OP_DEC;
            r_next.addr = phys_addr(instr_word[7:0], instr_word[cbde_pkg::BANK_BIT],
                                    bank_select_register, ext_set_en, index_base);
            r_next.re = 1'b1;
          end else if (instr_word == cbde_pkg::ADJ_WORD) begin
            r_next.op = cbde_pkg::CBDE_OP_ADJ;
          end
        end
      end
      cbde_pkg::Q2: begin
        r_next.less = 1'b0;
      end
      cbde_pkg::Q3: begin
        case (r_reg.op)
          cbde_pkg::CBDE_OP_CMP: begin
            r_next.less = mem_rdata < r_reg.w;
          end
          cbde_pkg::CBDE_OP_DEC: begin
            r_next.res = dec_res;
            r_next.res_c = mem_rdata != cbde_pkg::ZERO;
            r_next.res_dcy = mem_rdata[3:0] != cbde_pkg::NIB_ZERO;
            r_next.res_n = dec_res[7];
            r_next.res_vf = mem_rdata == cbde_pkg::VF_EDGE;
            r_next.res_z = dec_res == cbde_pkg::ZERO;
            r_next.we = r_reg.d;
            r_next.wdata = dec_res;
          end
          cbde_pkg::CBDE_OP_ADJ: begin
            r_next.res = adj_hi[7:0];
            r_next.res_c = adj_hi[8];
          end
          default: begin
            r_next.res = r_reg.res;
          end
        endcase
      end
      cbde_pkg::Q4: begin
        case (r_reg.op)
          cbde_pkg::CBDE_OP_DEC: begin
            if (!r_reg.d) begin
              r_next.w = r_reg.res;
            end
            r_next.c = r_reg.res_c;
            r_next.dcy = r_reg.res_dcy;
            r_next.n = r_reg.res_n;
            r_next.vf = r_reg.res_vf;
            r_next.z = r_reg.res_z;
          end
          cbde_pkg::CBDE_OP_ADJ: begin
            r_next.w = r_reg.res;
            r_next.c = r_reg.c | r_reg.res_c;
          end
          default: begin
            r_next.w = r_reg.w;
          end
        endcase
        case (r_reg.state)
          cbde_pkg::CBDE_EXEC: begin
            if (r_reg.op == cbde_pkg::CBDE_OP_CMP && r_reg.less) begin
              r_next.flush = 1'b1;
              r_next.state = next_two_word ? cbde_pkg::CBDE_SKIP_A
                                           : cbde_pkg::CBDE_SKIP_B;
            end
          end
          cbde_pkg::CBDE_SKIP_A: begin
            r_next.state = cbde_pkg::CBDE_SKIP_B;
          end
          cbde_pkg::CBDE_SKIP_B: begin
            r_next.state = cbde_pkg::CBDE_EXEC;
          end
          default: begin
            r_next.state = cbde_pkg::CBDE_EXEC;
          end
        endcase
        r_next.idle = r_next.state != cbde_pkg::CBDE_EXEC;
        r_next.op = cbde_pkg::CBDE_OP_NONE;
      end
      default: begin
        r_next.op = r_reg.op;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_phase = q;
  assign mem_addr = r_reg.addr;
  assign mem_re = r_reg.re;
  assign mem_we = r_reg.we;
  assign mem_wdata = r_reg.wdata;
  assign working_register_file = r_reg.w;
  assign carry_flag = r_reg.c;
  assign digit_carry_flag = r_reg.dcy;
  assign negative_flag = r_reg.n;
  assign overflow_flag = r_reg.vf;
  assign zero_flag = r_reg.z;
  assign skip_flush = r_reg.flush;
  assign skip_idle = r_reg.idle;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_sync);

  logic [4:0] flags;
  assign flags = {r_reg.c, r_reg.dcy, r_reg.n, r_reg.vf, r_reg.z};

  a_cmp_decode: assert property (
    (q == cbde_pkg::Q1 && r_reg.state == cbde_pkg::CBDE_EXEC && instr_valid
     && instr_word[15:9] == cbde_pkg::CMP_OPC)
    |=> (r_reg.op == cbde_pkg::CBDE_OP_CMP && r_reg.f == $past(instr_word[7:0])))
    else $error("compare not decoded");
  a_cmp_less: assert property (
    (q == cbde_pkg::Q3 && r_reg.op == cbde_pkg::CBDE_OP_CMP)
    |=> (r_reg.less == ($past(mem_rdata) < r_reg.w)))
    else $error("compare result wrong");
  a_skip_flush: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_CMP && r_reg.less)
    |=> (skip_flush && skip_idle))
    else $error("skip did not flush");
  a_skip_one: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_CMP && r_reg.less && !next_two_word)
    |=> skip_idle [*4] ##1 !skip_idle)
    else $error("single skip length wrong");
  a_skip_two: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_CMP && r_reg.less && next_two_word)
    |=> skip_idle [*8] ##1 !skip_idle)
    else $error("double skip length wrong");
  a_idle_quiet: assert property (
    skip_idle |-> (!mem_re && !mem_we && r_reg.op == cbde_pkg::CBDE_OP_NONE))
    else $error("activity during skip cycle");
  a_cmp_flags: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_CMP) |=> $stable(flags))
    else $error("compare changed flags");
  a_bank_sel: assert property (
    (mem_re && r_reg.a) |-> mem_addr == {$past(bank_select_register), r_reg.f})
    else $error("bank select address wrong");
  a_cmp_nowrite: assert property (
    (mem_re |-> q == cbde_pkg::Q2) and (r_reg.op == cbde_pkg::CBDE_OP_CMP |-> !mem_we))
    else $error("compare access out of phase");
  a_dec_store: assert property (
    (q == cbde_pkg::Q3 && r_reg.op == cbde_pkg::CBDE_OP_DEC && r_reg.d)
    |=> (mem_we && mem_wdata == 8'($past(mem_rdata) - cbde_pkg::ONE)))
    else $error("decrement write wrong");
  a_dec_flags: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_DEC)
    |=> (zero_flag == ($past(r_reg.res) == cbde_pkg::ZERO)
         && negative_flag == $past(r_reg.res[7])))
    else $error("decrement flags wrong");
  a_dec_to_work: assert property (
    (q == cbde_pkg::Q3 && r_reg.op == cbde_pkg::CBDE_OP_DEC && !r_reg.d)
    |=> (!mem_we ##1 working_register_file == 8'($past(mem_rdata, 2) - cbde_pkg::ONE)))
    else $error("decrement to working register wrong");
  a_dec_carry: assert property (
    (q == cbde_pkg::Q3 && r_reg.op == cbde_pkg::CBDE_OP_DEC)
    |=> ##1 (carry_flag == ($past(mem_rdata, 2) != cbde_pkg::ZERO)
             && overflow_flag == ($past(mem_rdata, 2) == cbde_pkg::VF_EDGE)))
    else $error("decrement carry or overflow wrong");
  a_adj_carry: assert property (
    (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_ADJ)
    |=> (working_register_file == $past(r_reg.res)
         && (carry_flag || !$past(r_reg.res_c))))
    else $error("decimal adjust writeback wrong");

  c_skip_one: cover property (skip_flush && !r_reg.state[0]);
  c_skip_two: cover property (skip_flush && r_reg.state[0]);
  c_dec_write: cover property (mem_we);
  c_dec_to_work: cover property (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_DEC
                                 && !r_reg.d);
  c_adj_carry: cover property (q == cbde_pkg::Q4 && r_reg.op == cbde_pkg::CBDE_OP_ADJ
                               && r_reg.res_c);
endmodule

// ===== verification/cbde_tb.sv
/*
  Self-checking bench for cbde_exec: drives instruction words, models data memory.
  Assumes the design's own assertions and covers stand in its files.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [11:0] addr; logic re; logic we; logic [7:0] wd;
    logic [7:0] w; logic [4:0] fl; logic sk; logic [3:0] idle;
  } cbde_note_t;
  logic mclk = 0, rstn = 0, instr_valid = 0, next_two_word = 0, ext_set_en = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000, mem_addr, s_addr, ad_d;
  logic [7:0] mem_rdata = 8'h00, mem_wdata, working_register_file, w_m = 8'h00, s_wd;
  logic [1:0] q_phase;
  logic mem_re, mem_we, skip_flush, skip_idle, s_re, s_we, re_d, armed = 0;
  logic carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag;
  logic [4:0] fl_m = 5'h00;
  logic [4:0] fl_s;
  assign fl_s = {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag};
  logic [7:0] mem [4096];
  logic [31:0] xs = 32'd75406;
  int err_total = 0, n_tests = 0, idle_m = 0, idle_cnt = 0;
  cbde_note_t nq[$];
  always #50 mclk = ~mclk;
  cbde_exec u_cbde_exec (.mclk(mclk), .rstn(rstn), .instr_word(instr_word),
    .instr_valid(instr_valid), .next_two_word(next_two_word),
    .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_rdata(mem_rdata), .q_phase(q_phase),
    .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .working_register_file(working_register_file), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .negative_flag(negative_flag),
    .overflow_flag(overflow_flag), .zero_flag(zero_flag), .skip_flush(skip_flush),
    .skip_idle(skip_idle));
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Data memory: read data appears in the clock after the read pulse, else toggles
  always @(posedge mclk) begin
    re_d = mem_re;
    ad_d = mem_addr;
    if (mem_we === 1'b1) mem[mem_addr] = mem_wdata;
    #1;
    if (re_d === 1'b1) mem_rdata = mem[ad_d];
    else mem_rdata = ~mem_rdata;
  end
  // Monitor: gathers one instruction's traffic, compares at the following Q1
  always @(negedge mclk) begin
    cbde_note_t n;
    if (q_phase === 2'h1) begin
      s_addr = mem_addr;
      s_re = mem_re;
      armed = nq.size() > 0;
    end
    if (q_phase === 2'h3) begin
      s_we = mem_we;
      s_wd = mem_wdata;
    end
    if (q_phase === 2'h0 && armed) begin
      n = nq.pop_front();
      armed = 0;
      check(16'(s_re), 16'(n.re));
      if (n.re) check(16'(s_addr), 16'(n.addr));
      check(16'(s_we), 16'(n.we));
      if (n.we) check(16'(s_wd), 16'(n.wd));
      check(16'(working_register_file), 16'(n.w));
      check(16'(fl_s), 16'(n.fl));
      check(16'(skip_flush), 16'(n.sk));
      check(16'(idle_cnt), 16'(n.idle));
      idle_cnt = 0;
    end
    if (skip_idle === 1'b1) idle_cnt++;
  end
  task automatic wait_q1();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      if (q_phase !== 2'h0) instr_valid = 0;
      k++;
    end while (q_phase !== 2'h0 && k < 8);
  endtask
  task automatic slot(input logic [15:0] wd, input logic v);
    wait_q1();
    instr_word = wd;
    instr_valid = v;
  endtask
  task automatic run(input logic [1:0] op, input logic [7:0] f, input logic a,
                     input logic d, input logic [7:0] val);
    cbde_note_t n;
    logic [11:0] ad;
    logic [8:0] t;
    logic [7:0] r;
    for (int i = 0; i < idle_m / 4; i++) slot(cbde_pkg::ADJ_WORD, 1'b1); // Ignored in skip
    wait_q1();
    bank_select_register = 4'(rnd());
    ext_set_en = 1'(rnd());
    index_base = 12'(rnd());
    next_two_word = 1'(rnd());
    n = '0;
    n.idle = 4'(idle_m);
    idle_m = 0;
    if (a) ad = {bank_select_register, f};
    else if (op == 2'h3 && ext_set_en && f <= 8'h5f) ad = index_base + {4'h0, f};
    else ad = f < 8'h80 ? {4'h0, f} : {4'hf, f};
    case (op)
      2'h1: begin
        instr_word = {cbde_pkg::CMP_OPC, a, f};
        n.re = 1;
        if (val < w_m) begin
          n.sk = 1;
          idle_m = next_two_word ? 8 : 4;
        end
      end
      2'h3: begin
        instr_word = {cbde_pkg::DEC_OPC, d, a, f};
        n.re = 1;
        r = val - 8'h01;
        fl_m = {val != 8'h00, val[3:0] != 4'h0, r[7], val == 8'h80, r == 8'h00};
        if (d) {n.we, n.wd} = {1'b1, r};
        else w_m = r;
      end
      default: begin
        instr_word = cbde_pkg::ADJ_WORD;
        t = {1'b0, w_m};
        if (t[3:0] > 4'h9 || fl_m[3]) t = t + 9'h006;
        if (t[7:4] > 4'h9 || t[8] || fl_m[4]) t = t + 9'h060;
        fl_m[4] = fl_m[4] | t[8];
        w_m = t[7:0];
      end
    endcase
    n.addr = ad;
    n.w = w_m;
    n.fl = fl_m;
    mem[ad] = val;
    instr_valid = 1;
    nq.push_back(n);
  endtask
  // Load W, then set carry pair from a decrement written back, then adjust
  task automatic adj_case(input logic [7:0] w, input logic [7:0] sel);
    run(2'h3, 8'(rnd()), 1'(rnd()), 1'b0, w + 8'h01);
    run(2'h3, 8'(rnd()), 1'(rnd()), 1'b1, sel);
    run(2'h2, 8'h00, 1'b0, 1'b0, 8'h00);
  endtask
  initial begin
    static logic [7:0] tb_v [4] = '{8'h00, 8'h01, 8'h80, 8'h10};
    repeat (6) @(posedge mclk);
    #1 rstn = 1;
    repeat (2) @(posedge mclk);
    run(2'h2, 8'h00, 1'b0, 1'b0, 8'h00);
    slot(16'hffff, 1'b1);
    slot({cbde_pkg::DEC_OPC, 2'h0, 8'h05}, 1'b0);
    $display("TEST reset done");
    adj_case(8'ha5, 8'h00);
    adj_case(8'hce, 8'h00);
    $display("TEST examples done");
    for (int i = 0; i < 80; i++) begin
      case (rnd() % 3)
        0: run(2'h1, 8'(rnd()), 1'(rnd()), 1'b0, w_m + 8'(rnd() % 3) - 8'h01);
        1: run(2'h3, 8'(rnd()), 1'(rnd()), 1'(rnd()), rnd() % 2 ? tb_v[rnd() % 4] : 8'(rnd()));
        default: adj_case(8'(rnd() % 240), tb_v[rnd() % 4]);
      endcase
    end
    $display("TEST random done");
    repeat (16) @(posedge mclk);
    end_of_test();
  end
  initial begin
    #(cbde_pkg::CYCLE_NS * 2000);
    err_total++;
    end_of_test();
  end
endmodule
